// ---- hdl/gauge_power_mode_manager.sv ----
// power-mode sequencer for a battery gauge
module gauge_power_mode_manager
    import gauge_power_pkg::*;
#(
    parameter int STALL_CYCLES = STALL_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int MEAS_CYCLES = MEAS_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire cfg_t cfg,
    input wire meas_t meas,
    input wire logic dormantRequestCmd,
    input wire logic busSclIn,
    input wire logic busSdaIn,
    input wire logic busNeedStall,
    input wire logic swResetPulse,
    input wire logic [1:0] swResetType,
    input wire logic [1:0] restartCountQuery,
    output logic [5:0] mode,
    output logic dormantRequest,
    output logic calStart,
    output logic measureTick,
    output logic hfOscEnable,
    output logic holdReported,
    output logic busHoldLow_n,
    output logic powerOffPin,
    output logic [15:0] restartCount
);
    mode_t state;
    logic [31:0] timer;
    logic [31:0] stallCnt;
    logic [31:0] holdCnt;
    logic [31:0] measCnt;
    logic sclD;
    logic sdaD;
    logic busEdge;
    logic [15:0] rstCnt [RST_TYPES];
    logic absLow;
    logic dozeOk;
    logic cutLatched;
    logic holdD;
    logic [31:0] lowRun;

    function automatic logic [15:0] absVal(input logic signed [15:0] v);
        absVal = v[15] ? 16'(-v) : 16'(v);
    endfunction : absVal

    // any edge on either line counts as activity, except the edges of
    // our own stall: pulling the lines low must not wake us from doze
    assign busEdge = ((busSclIn != sclD) || (busSdaIn != sdaD))
        && busHoldLow_n && holdD;
    assign absLow = absVal(meas.meanCurrent) < cfg.dormantCurrentLimit;
    assign dozeOk = cfg.dozeEnable && !meas.wakeCurrent
        && (absVal(meas.meanCurrent) < cfg.dozeCurrentLimit);

    always_ff @(posedge clk) begin
        if (srst) begin
            sclD <= 1'b1;
            sdaD <= 1'b1;
            holdD <= 1'b1;
        end else if (clkEn) begin
            sclD <= busSclIn;
            sdaD <= busSdaIn;
            holdD <= busHoldLow_n;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_NORMAL;
            timer <= '0;
            cutLatched <= 1'b0;
        end else if (clkEn) begin
            case (state)
                ST_NORMAL: begin
                    cutLatched <= 1'b0;
                    if (meas.ocvValid && meas.cellVoltage
                            < cfg.dormantVoltageLimit) begin
                        state <= ST_DORMANT;
                        cutLatched <= cfg.powerCutEnable;
                    end else if (dormantRequest && meas.ocvValid
                            && absLow) begin
                        state <= ST_DORMANT;
                    end else if (dozeOk) begin
                        state <= ST_CAL;
                        timer <= 32'(CAL_CYC);
                    end
                end
                ST_CAL: begin
                    if (!dozeOk) begin
                        state <= ST_NORMAL;
                    end else if (timer <= 32'd1) begin
                        state <= ST_DOZE;
                        timer <= cfg.deepDozeDelay;
                    end else begin
                        timer <= timer - 32'd1;
                    end
                end
                ST_DOZE: begin
                    if (!dozeOk || busEdge) begin
                        state <= ST_NORMAL;
                    end else if (cfg.deepDozeEnable
                            && $signed(timer) <= 0) begin
                        state <= ST_DEEP;
                    end else if (cfg.deepDozeEnable) begin
                        timer <= timer - 32'd1;
                    end
                end
                ST_DEEP: begin
                    if (busEdge || !dozeOk) begin
                        state <= ST_NORMAL;
                    end
                end
                ST_DORMANT: begin
                    if (busEdge) begin
                        state <= ST_WAKE;
                    end
                end
                default: begin
                    state <= ST_NORMAL;
                    cutLatched <= 1'b0;
                end
            endcase
        end
    end

    // request cleared on dormant exit; a new command in the same cycle wins
    always_ff @(posedge clk) begin
        if (srst) begin
            dormantRequest <= 1'b0;
        end else if (clkEn) begin
            if (dormantRequestCmd) begin
                dormantRequest <= 1'b1;
            end else if (state == ST_DORMANT && busEdge) begin
                dormantRequest <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            holdCnt <= '0;
            holdReported <= 1'b0;
        end else if (clkEn) begin
            if (state == ST_WAKE) begin
                holdCnt <= 32'(HOLD_CYCLES);
                holdReported <= 1'b1;
            end else if (holdCnt > 32'd1) begin
                holdCnt <= holdCnt - 32'd1;
            end else begin
                holdCnt <= '0;
                holdReported <= 1'b0;
            end
        end
    end

    // periodic measurement: every cycle in normal, slow tick in doze
    always_ff @(posedge clk) begin
        if (srst) begin
            measCnt <= '0;
            measureTick <= 1'b0;
        end else if (clkEn) begin
            if (state == ST_DOZE || state == ST_DEEP) begin
                measureTick <= (measCnt == '0);
                measCnt <= (measCnt == '0) ? 32'(MEAS_CYCLES - 1)
                    : measCnt - 32'd1;
            end else begin
                measureTick <= (state == ST_NORMAL);
                measCnt <= '0;
            end
        end
    end

    // stall is bounded so the host never waits past the limit
    always_ff @(posedge clk) begin
        if (srst) begin
            stallCnt <= '0;
            busHoldLow_n <= 1'b1;
        end else if (clkEn) begin
            if ((state == ST_DOZE || state == ST_DEEP) && busNeedStall
                    && stallCnt < 32'(STALL_CYCLES)) begin
                stallCnt <= stallCnt + 32'd1;
                busHoldLow_n <= 1'b0;
            end else begin
                if (!busNeedStall) begin
                    stallCnt <= '0;
                end
                busHoldLow_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode <= ST_NORMAL;
            calStart <= 1'b0;
            hfOscEnable <= 1'b1;
            powerOffPin <= 1'b0;
        end else if (clkEn) begin
            mode <= state;
            calStart <= (state == ST_NORMAL) && dozeOk
                && !(meas.ocvValid
                && meas.cellVoltage < cfg.dormantVoltageLimit)
                && !(dormantRequest && meas.ocvValid && absLow);
            hfOscEnable <= (state != ST_DEEP)
                && (state != ST_DORMANT);
            powerOffPin <= (state == ST_DORMANT && cutLatched)
                ? cfg.shutdownLevel : cfg.normalLevel;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < RST_TYPES; gi++) begin : g_rst
            always_ff @(posedge clk) begin
                if (srst) begin
                    rstCnt[gi] <= RESET_CNT_ZERO;
                end else if (clkEn && swResetPulse
                        && swResetType == 2'(gi)) begin
                    rstCnt[gi] <= rstCnt[gi] + 16'h0001;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            restartCount <= RESET_CNT_ZERO;
        end else if (clkEn) begin
            restartCount <= rstCnt[restartCountQuery];
        end
    end

    // length of the current low stretch on the stall output, counted
    // apart from the stall counter so the bound check is independent
    always_ff @(posedge clk) begin
        if (srst) begin
            lowRun <= '0;
        end else if (clkEn && !busHoldLow_n) begin
            lowRun <= lowRun + 32'd1;
        end else if (clkEn) begin
            lowRun <= '0;
        end
    end

    a_doze_needs_cal: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_DOZE && $past(state) != ST_DOZE
        |-> $past(state) == ST_CAL)
        else $error("doze entered without calibration");
    a_doze_enable: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && $past(clkEn) && state == ST_CAL && $past(state) == ST_NORMAL
        |-> $past(cfg.dozeEnable))
        else $error("calibration without doze enable");
    a_deep_from_doze: assert property (
        @(posedge clk) disable iff (srst)
        state == ST_DEEP && $past(state) != ST_DEEP
        |-> $past(state) == ST_DOZE)
        else $error("deep doze entered not from doze");
    a_deep_wake: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_DEEP && busEdge |=> state == ST_NORMAL)
        else $error("deep doze ignored activity");
    a_dormant_wake: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_DORMANT && busEdge
        |=> state == ST_WAKE
        ##0 (!dormantRequest || $past(dormantRequestCmd)))
        else $error("dormant exit wrong");
    a_osc_off: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_DEEP |=> !hfOscEnable)
        else $error("oscillator running in deep doze");
    a_pin_normal: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state != ST_DORMANT
        |=> powerOffPin == $past(cfg.normalLevel))
        else $error("shutdown level outside dormant");
    a_stall_bound: assert property (
        @(posedge clk) disable iff (srst)
        lowRun <= 32'(STALL_CYCLES))
        else $error("bus stall too long");
    a_stall_mode: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state != ST_DOZE && state != ST_DEEP |=> busHoldLow_n)
        else $error("bus stalled outside doze");
    a_hold_wake: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_WAKE |=> holdReported)
        else $error("old values not held after dormant");
    a_volt_dormant: assert property (
        @(posedge clk) disable iff (srst)
        clkEn && state == ST_NORMAL && meas.ocvValid
        && meas.cellVoltage < cfg.dormantVoltageLimit
        |=> state == ST_DORMANT)
        else $error("low voltage did not enter dormant");
    c_doze: cover property (@(posedge clk) state == ST_DOZE);
    c_deep: cover property (@(posedge clk) state == ST_DEEP);
    c_dormant_exit: cover property (@(posedge clk)
        state == ST_DORMANT ##1 state == ST_WAKE);
    c_stall_end: cover property (@(posedge clk)
        !busHoldLow_n ##1 busHoldLow_n);
endmodule : gauge_power_mode_manager

// ---- hdl/gauge_power_pkg.sv ----
// constants and types for the gauge power-mode manager
// Operation
// - three modes plus deep doze from doze
// - normal when no other mode active
// - doze needs enable and low current
// - offset calibration before doze entry
// - doze may stall bus up to 4ms
// - periodic measurement, idle otherwise in doze
// - leave doze when any condition fails
// - deep doze after countdown, immediate if <=0
// - bus activity ends deep doze
// - oscillator stopped in deep doze
// - current dormant needs request, valid voltage
// - low voltage with valid reading forces dormant; checked only in normal, not in calibration, doze or deep doze
// - power cut drives shutdown pin state; only on low-voltage dormant entry, not on current (requested) dormant
// - dormant until bus activity, then normal
// - dormant exit clears dormant request
// - hold old values three seconds after dormant
// - software reset counted by type
// - shutdown pin state only in dormant
package gauge_power_pkg;
    localparam int CLK_MHZ = 200;
    localparam int STALL_US = 4000;
    localparam int STALL_CYC = STALL_US * CLK_MHZ;
    localparam int HOLD_MS = 3000;
    localparam int HOLD_CYC = HOLD_MS * CLK_MHZ * 1000;
    localparam int MEAS_PERIOD_CYC = 200000;
    localparam int CAL_CYC = 64;
    localparam logic [15:0] RESET_CNT_ZERO = 16'h0000;
    localparam int RST_TYPES = 4;

    typedef enum logic [5:0] {
        ST_NORMAL = 6'b00_0001,
        ST_CAL = 6'b00_0010,
        ST_DOZE = 6'b00_0100,
        ST_DEEP = 6'b00_1000,
        ST_DORMANT = 6'b01_0000,
        ST_WAKE = 6'b10_0000
    } mode_t;

    typedef struct packed {
        logic dozeEnable;
        logic deepDozeEnable;
        logic powerCutEnable;
        logic shutdownLevel;
        logic normalLevel;
        logic signed [31:0] deepDozeDelay;
        logic [15:0] dozeCurrentLimit;
        logic [15:0] dormantCurrentLimit;
        logic [15:0] dormantVoltageLimit;
    } cfg_t;

    typedef struct packed {
        logic signed [15:0] meanCurrent;
        logic [15:0] cellVoltage;
        logic ocvValid;
        logic wakeCurrent;
    } meas_t;
endpackage : gauge_power_pkg

// ---- tb/host_bus_model.sv ----
// host side of the serial bus: two pulled-up lines
module host_bus_model (
    input wire logic clk,
    input wire logic poke,
    input wire logic holdLow_n,
    output logic scl,
    output logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sdaDrive = 1'h1;
    // two-line bus only, never single-wire, so dormant may stay on
    // one data edge is enough traffic to wake the gauge
    always @(posedge clk) if (poke) sdaDrive <= ~sdaDrive;
    // host just waits while the gauge pulls the lines low
    assign scl = holdLow_n;
    assign sda = sdaDrive & holdLow_n;
endmodule : host_bus_model

// ---- tb/gauge_power_mode_manager_bench.sv ----
// self-checking bench for the gauge power-mode manager
module gauge_power_mode_manager_bench
    import gauge_power_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, clkEn, dormantRequestCmd, poke, busNeedStall;
    logic swResetPulse, scl, sda, calStart, measureTick, hfOscEnable;
    logic dormantRequest, holdReported, busHoldLow_n, powerOffPin;
    logic [1:0] swResetType, restartCountQuery;
    logic [5:0] mode;
    logic [15:0] restartCount;
    cfg_t cfg;
    meas_t meas;
    int n_errors = 0;
    int checks = 0;
    int i;

    gauge_power_mode_manager #(.STALL_CYCLES(50), .HOLD_CYCLES(100),
        .MEAS_CYCLES(20)) dut_u (.clk(clk), .srst(srst), .clkEn(clkEn),
        .cfg(cfg), .meas(meas), .dormantRequestCmd(dormantRequestCmd),
        .busSclIn(scl), .busSdaIn(sda), .busNeedStall(busNeedStall),
        .swResetPulse(swResetPulse), .swResetType(swResetType),
        .restartCountQuery(restartCountQuery), .mode(mode),
        .dormantRequest(dormantRequest), .calStart(calStart),
        .measureTick(measureTick), .hfOscEnable(hfOscEnable),
        .holdReported(holdReported), .busHoldLow_n(busHoldLow_n),
        .powerOffPin(powerOffPin), .restartCount(restartCount));
    host_bus_model host_u (.clk(clk), .poke(poke),
        .holdLow_n(busHoldLow_n), .scl(scl), .sda(sda));

    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen,
                exp);
        end
    endtask : check

    // bounded wait on the stall line (sel 0) or the hold flag (sel 1);
    // read live each cycle, a task input would only hold a copy
    task automatic waitFor(input bit sel, input logic exp,
        input int bound, output int n);
        for (n = 0; n < bound && (sel ? holdReported : busHoldLow_n) !== exp;
                n++) @(negedge clk);
        if ((sel ? holdReported : busHoldLow_n) !== exp) begin
            n_errors++;
            $display("wrong value at %0t: wait ran out", $time);
            test_done();
        end
    endtask : waitFor

    task automatic waitMode(input logic [5:0] m, input int bound);
        int k;
        for (k = 0; k < bound && mode !== m; k++) @(negedge clk);
        check(mode, m);
        if (mode !== m)
            test_done();
    endtask : waitMode

    task automatic wake;
        @(posedge clk) poke <= 1'h1;
        @(posedge clk) poke <= 1'h0;
    endtask : wake

    task automatic tReset;
        @(negedge clk);
        check(mode, ST_NORMAL);
        check(measureTick, 1'h1);
        check(hfOscEnable, 1'h1);
        check(powerOffPin, cfg.normalLevel);
    endtask : tReset

    task automatic tDoze;
        int n;
        @(posedge clk) cfg.dozeEnable <= 1'h1;
        for (n = 0; n < 10 && calStart !== 1'h1; n++) @(negedge clk);
        check(calStart, 1'h1);
        repeat (10) @(negedge clk);
        check(mode, ST_CAL);
        waitMode(ST_DOZE, 70);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            n += measureTick;
        end
        check(n, 2);
        @(posedge clk) meas.meanCurrent <= 16'h0400;
        waitMode(ST_NORMAL, 10);
        @(posedge clk) meas.meanCurrent <= 16'h0064;
        waitMode(ST_DOZE, 80);
        @(posedge clk) meas.wakeCurrent <= 1'h1;
        waitMode(ST_NORMAL, 10);
        @(posedge clk) meas.wakeCurrent <= 1'h0;
        cfg.deepDozeEnable <= 1'h1;
        waitMode(ST_DEEP, 90);
        check(hfOscEnable, 1'h0);
        wake();
        waitMode(ST_NORMAL, 10);
        waitMode(ST_DOZE, 80);
        @(posedge clk) busNeedStall <= 1'h1;
        cfg.deepDozeEnable <= 1'h0;
        waitFor(1'b0, 1'h0, 10, n);
        waitFor(1'b0, 1'h1, 60, n);
        check(n <= 51, 1'h1);
        @(posedge clk) busNeedStall <= 1'h0;
        cfg.dozeEnable <= 1'h0;
        waitMode(ST_NORMAL, 80);
    endtask : tDoze

    task automatic tDormant;
        int n;
        // voltage entry ignores the request bit and may cut power
        @(posedge clk) cfg.powerCutEnable <= 1'h1;
        cfg.dormantVoltageLimit <= 16'h0e00;
        meas.ocvValid <= 1'h1;
        meas.cellVoltage <= 16'h0d00;
        waitMode(ST_DORMANT, 10);
        @(negedge clk);
        check(powerOffPin, cfg.shutdownLevel);
        @(posedge clk) meas.cellVoltage <= 16'h0f00;
        repeat (5) @(negedge clk);
        check(mode, ST_DORMANT);
        wake();
        waitMode(ST_NORMAL, 10);
        @(negedge clk);
        check(powerOffPin, cfg.normalLevel);
        repeat (90) @(negedge clk);
        check(holdReported, 1'h1);
        waitFor(1'b1, 1'h0, 20, n);
        // current entry needs the request; zero limits keep it off
        @(posedge clk) cfg.dormantVoltageLimit <= 16'h0000;
        cfg.dormantCurrentLimit <= 16'h0080;
        repeat (20) @(negedge clk);
        check(mode, ST_NORMAL);
        @(posedge clk) dormantRequestCmd <= 1'h1;
        @(posedge clk) dormantRequestCmd <= 1'h0;
        waitMode(ST_DORMANT, 10);
        check(dormantRequest, 1'h1);
        check(powerOffPin, cfg.normalLevel);
        wake();
        waitMode(ST_NORMAL, 10);
        check(dormantRequest, 1'h0);
        @(posedge clk) cfg.dormantCurrentLimit <= 16'h0000;
    endtask : tDormant

    task automatic tResetCount;
        for (int t = 0; t < 4; t++) begin
            repeat (t + 1) begin
                @(posedge clk) swResetPulse <= 1'h1;
                swResetType <= 2'(t);
                @(posedge clk) swResetPulse <= 1'h0;
            end
        end
        for (int t = 0; t < 4; t++) begin
            @(posedge clk) restartCountQuery <= 2'(t);
            repeat (3) @(negedge clk);
            check(restartCount, 16'(t + 1));
        end
        // clock enable low freezes the counters: this pulse must not count
        @(posedge clk) clkEn <= 1'h0;
        swResetPulse <= 1'h1;
        swResetType <= 2'h1;
        @(posedge clk) swResetPulse <= 1'h0;
        clkEn <= 1'h1;
        restartCountQuery <= 2'h1;
        repeat (3) @(negedge clk);
        check(restartCount, 16'h0002);
    endtask : tResetCount

    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        srst = 1'h1;
        clkEn = 1'h1;
        cfg = '0;
        cfg.shutdownLevel = 1'h1;
        cfg.dozeCurrentLimit = 16'h0200;
        meas = '0;
        meas.meanCurrent = 16'h0064;
        meas.cellVoltage = 16'h0f00;
        {dormantRequestCmd, poke, busNeedStall, swResetPulse} = 4'h0;
        swResetType = 2'h0;
        restartCountQuery = 2'h0;
        repeat (16) @(posedge clk);
        srst <= 1'h0;
        repeat (3) @(posedge clk);
        tReset();
        tDoze();
        tDormant();
        tResetCount();
        test_done();
    end
endmodule : gauge_power_mode_manager_bench
